/* File: pkg/pcs_ctrl_map.vh */
// What this block does
// - test mode needs both tx and rx enables
// - square, pseudo-random, prbs31, user patterns supported
// - user mode loads no scrambler seed
// - separate tx and rx pattern selects
// - square wave period from period field
// - pseudo-random inverts unless no-invert bits set
// - seed b is 26 high plus 32 low
// - tx and rx 64-bit patterns, two halves
// - match flag high only while pattern matches
// - error counter cleared by writing zero
// - rx invert flips all serdes data bits
// - rx reverse swaps lane order 0-3
// - tx invert and tx lane reverse provided
// - base-r tx and rx bit order flip
// - readable wake error count and idle status
// - error indication marks uncorrectable blocks to pcs
// - lock loss sets sticky flag
// - fec counters cleared by reset 1 then 0
// - counter crossing limit sets sticky flag
// - seed a is 26 high plus 32 low
`ifndef PCS_CTRL_MAP_VH
`define PCS_CTRL_MAP_VH
// register word indices
`define A_TEST_CFG      6'h00
`define A_SEED_A_HIGH   6'h01
`define A_SEED_A_LOW    6'h02
`define A_SEED_B_HIGH   6'h03
`define A_SEED_B_LOW    6'h04
`define A_TX_PAT_HIGH   6'h05
`define A_TX_PAT_LOW    6'h06
`define A_RX_PAT_HIGH   6'h07
`define A_RX_PAT_LOW    6'h08
`define A_CHK_STATUS    6'h09
`define A_ERR_COUNT     6'h0a
`define A_LANE_CFG      6'h0b
`define A_XIDLE_CFG     6'h0c
`define A_XIDLE_STATUS  6'h0d
`define A_RIDLE_STATUS  6'h0e
`define A_WAKE_COUNT    6'h0f
`define A_FEC_CFG       6'h10
`define A_FEC_STATUS    6'h11
`define A_FEC_STICKY    6'h12
`define A_FEC_CORR      6'h13
`define A_FEC_UNCORR    6'h14
`define A_CORR_LIMIT    6'h15
`define A_UNCORR_LIMIT  6'h16
// test_cfg fields
`define TC_TX_EN        0
`define TC_RX_EN        1
`define TC_TX_SEL_LO    2
`define TC_RX_SEL_LO    4
`define TC_TX_NOINV     6
`define TC_RX_NOINV     7
`define TC_SQ_LO        8
// pattern select codes
`define PAT_SQUARE      2'h0
`define PAT_PSEUDO      2'h1
`define PAT_PRBS31      2'h2
`define PAT_USER        2'h3
// lane_cfg fields
`define LC_RX_INV       0
`define LC_RX_REV       1
`define LC_TX_INV       2
`define LC_TX_REV       3
`define LC_TX_FLIP      4
`define LC_RX_FLIP      5
// fec_config fields
`define FC_ON           0
`define FC_TX_FLIP      1
`define FC_RX_FLIP      2
`define FC_ERR_IND      3
`define FC_CNT_RST      4
// sticky fields
`define FS_LOCK         0
`define FS_CORR         1
`define FS_UNCORR       2
`define SEED_HI_W       26
`define CNT_MAX         32'hffff_ffff
`define ZERO32          32'h0000_0000
`endif

/* File: rtl/pcs_test_lane_fec_ctrl.v */
// Implementation choices: register access over Wishbone and the register offsets.
`timescale 1ns/1ps
`include "pcs_ctrl_map.vh"
module pcs_test_lane_fec_ctrl
(
   input  wire        clk,
   input  wire        rstn,
   input  wire        wb_cyc_i,
   input  wire        wb_stb_i,
   input  wire        wb_we_i,
   input  wire [7:0]  wb_adr_i,
   input  wire [3:0]  wb_sel_i,
   input  wire [31:0] wb_dat_i,
   output reg  [31:0] wb_dat_o,
   output reg         wb_ack_o,
   output reg         wb_err_o,
   input  wire [63:0] pcs_tx_data,
   output reg  [63:0] serdes_tx_data,
   input  wire [63:0] serdes_rx_data,
   output reg  [63:0] pcs_rx_data,
   output reg         test_mode_on,
   output reg         fec_on,
   output reg         fec_err_ind,
   output reg         fec_tx_flip,
   output reg         fec_rx_flip,
   input  wire        fec_lock,
   input  wire        fec_corr_evt,
   input  wire        fec_uncorr_evt,
   output reg         pcs_block_err,
   input  wire        wake_err_evt,
   input  wire [31:0] xaui_idle_status,
   input  wire [31:0] baser_idle_status,
   output reg  [31:0] xaui_idle_cfg
);

// ****************************************
// register storage
// ****************************************
reg  [31:0] test_cfg_q;
reg  [25:0] seed_a_high_q;
reg  [31:0] seed_a_low_q;
reg  [25:0] seed_b_high_q;
reg  [31:0] seed_b_low_q;
reg  [31:0] tx_pat_high_q;
reg  [31:0] tx_pat_low_q;
reg  [31:0] rx_pat_high_q;
reg  [31:0] rx_pat_low_q;
reg  [5:0]  lane_cfg_q;
reg  [4:0]  fec_cfg_q;
reg  [2:0]  sticky_q;
reg  [31:0] err_cnt_q;
reg  [31:0] wake_cnt_q;
reg  [31:0] corr_cnt_q;
reg  [31:0] uncorr_cnt_q;
reg  [31:0] corr_limit_q;
reg  [31:0] uncorr_limit_q;
reg         match_q;
reg         cnt_rst_seen_q;
reg  [57:0] lfsr_q;
reg  [30:0] prbs_q;
reg  [15:0] sq_cnt_q;
reg         sq_level_q;
reg  [63:0] chk_exp_q;
reg         chk_armed_q;
// async inputs pass two flip-flops
reg  [63:0] rx_s1_q;
reg  [63:0] rx_s2_q;
reg  [3:0]  ev_s1_q;
reg  [3:0]  ev_s2_q;
reg  [3:0]  ev_s3_q;

wire [1:0]  tx_sel    = test_cfg_q[`TC_TX_SEL_LO+1:`TC_TX_SEL_LO];
wire [1:0]  rx_sel    = test_cfg_q[`TC_RX_SEL_LO+1:`TC_RX_SEL_LO];
wire [15:0] sq_period = test_cfg_q[`TC_SQ_LO+15:`TC_SQ_LO];
wire        test_on   = test_cfg_q[`TC_TX_EN] & test_cfg_q[`TC_RX_EN];
wire        lock_now  = ev_s2_q[0];
wire        lock_fall = ev_s3_q[0] & ~ev_s2_q[0];
wire        corr_ev   = ev_s2_q[1] & ~ev_s3_q[1];
wire        uncorr_ev = ev_s2_q[2] & ~ev_s3_q[2];
wire        wake_ev   = ev_s2_q[3] & ~ev_s3_q[3];

// ****************************************
// helpers
// ****************************************
function [63:0] lane_rev;
   input [63:0] d;
   begin
      lane_rev = {d[15:0], d[31:16], d[47:32], d[63:48]};
   end
endfunction

function [63:0] bit_rev;
   input [63:0] d;
   integer i;
   begin
      for (i = 0; i < 64; i = i + 1)
         bit_rev[i] = d[63-i];
   end
endfunction

function [57:0] lfsr_next(input [57:0] s);
   lfsr_next = {s[56:0], s[57] ^ s[38]};
endfunction

function [63:0] lfsr_word(input [57:0] s);
   lfsr_word = {s, s[57:52]};
endfunction

function [30:0] prbs_next(input [30:0] s);
   prbs_next = {s[29:0], s[30] ^ s[27]};
endfunction

function [63:0] prbs_word(input [30:0] s);
   prbs_word = {s, s, s[1:0]};
endfunction

function [31:0] sat_inc;
   input [31:0] c;
   begin
      if (c == `CNT_MAX)
         sat_inc = c;
      else
         sat_inc = c + 32'h0000_0001;
   end
endfunction

function [31:0] merge;
   input [31:0] old;
   input [31:0] nw;
   input [3:0]  sel;
   integer k;
   begin
      for (k = 0; k < 4; k = k + 1)
         merge[k*8 +: 8] = sel[k] ? nw[k*8 +: 8] : old[k*8 +: 8];
   end
endfunction

// ****************************************
// pattern generation
// ****************************************
reg  [63:0] gen_word;
reg  [63:0] rx_lanes;
reg  [63:0] tx_lanes;
always @*
begin
   case (tx_sel)
      `PAT_SQUARE: gen_word = {64{sq_level_q}};
      `PAT_PSEUDO: gen_word = lfsr_word(lfsr_q) ^ ({tx_pat_high_q, tx_pat_low_q} ^
                              {64{~test_cfg_q[`TC_TX_NOINV]}});
      `PAT_PRBS31: gen_word = prbs_word(prbs_q);
      `PAT_USER:   gen_word = lfsr_word(lfsr_q) ^ {tx_pat_high_q, tx_pat_low_q};
      default:     gen_word = 64'h0000_0000_0000_0000;
   endcase
   tx_lanes = test_on ? gen_word : pcs_tx_data;
   if (lane_cfg_q[`LC_TX_INV])
      tx_lanes = ~tx_lanes;
   if (lane_cfg_q[`LC_TX_REV])
      tx_lanes = lane_rev(tx_lanes);
   if (lane_cfg_q[`LC_TX_FLIP])
      tx_lanes = bit_rev(tx_lanes);
   rx_lanes = rx_s2_q;
   if (lane_cfg_q[`LC_RX_FLIP])
      rx_lanes = bit_rev(rx_lanes);
   if (lane_cfg_q[`LC_RX_INV])
      rx_lanes = ~rx_lanes;
   if (lane_cfg_q[`LC_RX_REV])
      rx_lanes = lane_rev(rx_lanes);
end

// next word predicted from the current one, so the checker locks without a seed
reg  [63:0] exp_word;
reg  [63:0] pred_word;
reg  [63:0] rx_const;
always @*
begin
   rx_const = {rx_pat_high_q, rx_pat_low_q};
   if (rx_sel == `PAT_PSEUDO)
      rx_const = rx_const ^ {64{~test_cfg_q[`TC_RX_NOINV]}};
   if (rx_sel == `PAT_PRBS31)
      pred_word = prbs_word(prbs_next(rx_lanes[63:33]));
   else
      pred_word = lfsr_word(lfsr_next(rx_lanes[63:6] ^ rx_const[63:6])) ^ rx_const;
   exp_word = (rx_sel == `PAT_SQUARE) ? {64{rx_lanes[0]}} : chk_exp_q;
end

wire pat_ok = (rx_lanes == exp_word);
wire seed_ld = test_on & ~test_mode_on & (tx_sel != `PAT_USER);

always @(posedge clk or negedge rstn)
begin
   if (!rstn)
   begin
      lfsr_q       <= 58'h3ff_ffff_ffff_ffff;
      prbs_q       <= 31'h7fff_ffff;
      sq_cnt_q     <= 16'h0000;
      sq_level_q   <= 1'b0;
      chk_exp_q    <= 64'h0000_0000_0000_0000;
      chk_armed_q  <= 1'b0;
      match_q      <= 1'b0;
      rx_s1_q      <= 64'h0000_0000_0000_0000;
      rx_s2_q      <= 64'h0000_0000_0000_0000;
      ev_s1_q      <= 4'h0;
      ev_s2_q      <= 4'h0;
      ev_s3_q      <= 4'h0;
   end
   else
   begin
      rx_s1_q <= serdes_rx_data;
      rx_s2_q <= rx_s1_q;
      ev_s1_q <= {wake_err_evt, fec_uncorr_evt, fec_corr_evt, fec_lock};
      ev_s2_q <= ev_s1_q;
      ev_s3_q <= ev_s2_q;
      if (seed_ld)
         lfsr_q <= (tx_sel == `PAT_PSEUDO) ? {seed_a_high_q, seed_a_low_q}
                                           : {seed_b_high_q, seed_b_low_q};
      else if (test_on)
         lfsr_q <= lfsr_next(lfsr_q);
      if (test_on)
         prbs_q <= prbs_next(prbs_q);
      if (test_on && sq_cnt_q >= sq_period)
      begin
         sq_cnt_q   <= 16'h0000;
         sq_level_q <= ~sq_level_q;
      end
      else if (test_on)
         sq_cnt_q <= sq_cnt_q + 16'h0001;
      // checker self-synchronises on received data
      chk_armed_q <= test_on;
      chk_exp_q   <= pred_word;
      match_q     <= test_on & chk_armed_q & pat_ok;
   end
end

// ****************************************
// datapath outputs
// ****************************************
always @(posedge clk or negedge rstn)
begin
   if (!rstn)
   begin
      serdes_tx_data <= 64'h0000_0000_0000_0000;
      pcs_rx_data    <= 64'h0000_0000_0000_0000;
      test_mode_on   <= 1'b0;
      pcs_block_err  <= 1'b0;
   end
   else
   begin
      serdes_tx_data <= tx_lanes;
      pcs_rx_data    <= rx_lanes;
      test_mode_on   <= test_on;
      pcs_block_err  <= fec_cfg_q[`FC_ERR_IND] & fec_cfg_q[`FC_ON] & uncorr_ev;
   end
end

// ****************************************
// wishbone slave and registers
// ****************************************
wire        req    = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
wire [5:0]  widx   = wb_adr_i[7:2];
wire        wr     = req & wb_we_i;
wire [31:0] wd     = wb_dat_i;
wire        mapped = (widx <= `A_UNCORR_LIMIT);
wire        err_wr = wr & (widx == `A_ERR_COUNT) & (wd == `ZERO32);
wire        stk_wr = wr & (widx == `A_FEC_STICKY);
wire [31:0] stk_m  = merge(`ZERO32, wd, wb_sel_i);
wire [31:0] sa_hi_m = merge({6'h00, seed_a_high_q}, wd, wb_sel_i);
wire [31:0] sb_hi_m = merge({6'h00, seed_b_high_q}, wd, wb_sel_i);
wire        cnt_clr = cnt_rst_seen_q & ~fec_cfg_q[`FC_CNT_RST];
wire        ec_hit = test_on & chk_armed_q & ~pat_ok;

reg  [31:0] rd;
always @*
begin
   case (widx)
      `A_TEST_CFG:     rd = test_cfg_q;
      `A_SEED_A_HIGH:  rd = {6'h00, seed_a_high_q};
      `A_SEED_A_LOW:   rd = seed_a_low_q;
      `A_SEED_B_HIGH:  rd = {6'h00, seed_b_high_q};
      `A_SEED_B_LOW:   rd = seed_b_low_q;
      `A_TX_PAT_HIGH:  rd = tx_pat_high_q;
      `A_TX_PAT_LOW:   rd = tx_pat_low_q;
      `A_RX_PAT_HIGH:  rd = rx_pat_high_q;
      `A_RX_PAT_LOW:   rd = rx_pat_low_q;
      `A_CHK_STATUS:   rd = {31'h0000_0000, match_q};
      `A_ERR_COUNT:    rd = err_cnt_q;
      `A_LANE_CFG:     rd = {26'h000_0000, lane_cfg_q};
      `A_XIDLE_CFG:    rd = xaui_idle_cfg;
      `A_XIDLE_STATUS: rd = xaui_idle_status;
      `A_RIDLE_STATUS: rd = baser_idle_status;
      `A_WAKE_COUNT:   rd = wake_cnt_q;
      `A_FEC_CFG:      rd = {27'h000_0000, fec_cfg_q};
      `A_FEC_STATUS:   rd = {31'h0000_0000, lock_now};
      `A_FEC_STICKY:   rd = {29'h0000_0000, sticky_q};
      `A_FEC_CORR:     rd = corr_cnt_q;
      `A_FEC_UNCORR:   rd = uncorr_cnt_q;
      `A_CORR_LIMIT:   rd = corr_limit_q;
      `A_UNCORR_LIMIT: rd = uncorr_limit_q;
      default:         rd = `ZERO32;
   endcase
end

always @(posedge clk or negedge rstn)
begin
   if (!rstn)
   begin
      wb_ack_o       <= 1'b0;
      wb_err_o       <= 1'b0;
      wb_dat_o       <= `ZERO32;
      test_cfg_q     <= `ZERO32;
      seed_a_high_q  <= 26'h000_0000;
      seed_a_low_q   <= `ZERO32;
      seed_b_high_q  <= 26'h000_0000;
      seed_b_low_q   <= `ZERO32;
      tx_pat_high_q  <= `ZERO32;
      tx_pat_low_q   <= `ZERO32;
      rx_pat_high_q  <= `ZERO32;
      rx_pat_low_q   <= `ZERO32;
      lane_cfg_q     <= 6'h00;
      xaui_idle_cfg  <= `ZERO32;
      fec_cfg_q      <= 5'h00;
      corr_limit_q   <= `CNT_MAX;
      uncorr_limit_q <= `CNT_MAX;
      cnt_rst_seen_q <= 1'b0;
      sticky_q       <= 3'h0;
      err_cnt_q      <= `ZERO32;
      wake_cnt_q     <= `ZERO32;
      corr_cnt_q     <= `ZERO32;
      uncorr_cnt_q   <= `ZERO32;
      fec_on         <= 1'b0;
      fec_err_ind    <= 1'b0;
      fec_tx_flip    <= 1'b0;
      fec_rx_flip    <= 1'b0;
   end
   else
   begin
      wb_ack_o <= req & mapped;
      wb_err_o <= req & ~mapped;
      wb_dat_o <= (req & ~wb_we_i & mapped) ? rd : `ZERO32;
      if (wr)
      begin
         case (widx)
            `A_TEST_CFG:    test_cfg_q    <= merge(test_cfg_q, wd, wb_sel_i);
            `A_SEED_A_HIGH: seed_a_high_q <= sa_hi_m[`SEED_HI_W-1:0];
            `A_SEED_A_LOW:  seed_a_low_q  <= merge(seed_a_low_q, wd, wb_sel_i);
            `A_SEED_B_HIGH: seed_b_high_q <= sb_hi_m[`SEED_HI_W-1:0];
            `A_SEED_B_LOW:  seed_b_low_q  <= merge(seed_b_low_q, wd, wb_sel_i);
            `A_TX_PAT_HIGH: tx_pat_high_q <= merge(tx_pat_high_q, wd, wb_sel_i);
            `A_TX_PAT_LOW:  tx_pat_low_q  <= merge(tx_pat_low_q, wd, wb_sel_i);
            `A_RX_PAT_HIGH: rx_pat_high_q <= merge(rx_pat_high_q, wd, wb_sel_i);
            `A_RX_PAT_LOW:  rx_pat_low_q  <= merge(rx_pat_low_q, wd, wb_sel_i);
            `A_LANE_CFG:    if (wb_sel_i[0]) lane_cfg_q <= wd[5:0];
            `A_XIDLE_CFG:   xaui_idle_cfg <= merge(xaui_idle_cfg, wd, wb_sel_i);
            `A_FEC_CFG:     if (wb_sel_i[0]) fec_cfg_q <= wd[4:0];
            `A_CORR_LIMIT:  corr_limit_q  <= merge(corr_limit_q, wd, wb_sel_i);
            `A_UNCORR_LIMIT: uncorr_limit_q <= merge(uncorr_limit_q, wd, wb_sel_i);
            default:        ;
         endcase
      end
      fec_on      <= fec_cfg_q[`FC_ON];
      fec_err_ind <= fec_cfg_q[`FC_ERR_IND];
      fec_tx_flip <= fec_cfg_q[`FC_TX_FLIP];
      fec_rx_flip <= fec_cfg_q[`FC_RX_FLIP];
      // counter reset acts on the falling edge of the reset bit
      cnt_rst_seen_q <= fec_cfg_q[`FC_CNT_RST];
      // test error counter: zero write clears, hit in same cycle leaves it at one
      if (ec_hit)
         err_cnt_q <= err_wr ? 32'h0000_0001 : sat_inc(err_cnt_q);
      else if (err_wr)
         err_cnt_q <= `ZERO32;
      if (wake_ev)
         wake_cnt_q <= sat_inc(wake_cnt_q);
      if (cnt_clr)
         corr_cnt_q <= fec_on & corr_ev ? 32'h0000_0001 : `ZERO32;
      else if (fec_on & corr_ev)
         corr_cnt_q <= sat_inc(corr_cnt_q);
      if (cnt_clr)
         uncorr_cnt_q <= fec_on & uncorr_ev ? 32'h0000_0001 : `ZERO32;
      else if (fec_on & uncorr_ev)
         uncorr_cnt_q <= sat_inc(uncorr_cnt_q);
      // sticky bits: set wins over write-one-to-clear
      sticky_q[`FS_LOCK] <= (fec_on & lock_fall) |
                            (sticky_q[`FS_LOCK] & ~(stk_wr & stk_m[`FS_LOCK]));
      sticky_q[`FS_CORR] <= (corr_cnt_q > corr_limit_q) |
                            (sticky_q[`FS_CORR] & ~(stk_wr & stk_m[`FS_CORR]));
      sticky_q[`FS_UNCORR] <= (uncorr_cnt_q > uncorr_limit_q) |
                              (sticky_q[`FS_UNCORR] &
                               ~(stk_wr & stk_m[`FS_UNCORR]));
   end
end

endmodule

/* File: testbench/pcs_ctrl_checker.sv */
`timescale 1ns/1ps
module pcs_ctrl_checker
(
   input wire        clk,
   input wire        rstn,
   input wire        wb_cyc_i,
   input wire        wb_stb_i,
   input wire        wb_we_i,
   input wire [7:0]  wb_adr_i,
   input wire [31:0] wb_dat_o,
   input wire        wb_ack_o,
   input wire        wb_err_o,
   input wire        test_mode_on,
   input wire        fec_on,
   input wire        fec_err_ind,
   input wire        pcs_block_err
);
   default clocking @(posedge clk);
   endclocking
   default disable iff (!rstn);
   ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held longer than one cycle");
   ack_latency_a: assert property ($rose(wb_cyc_i && wb_stb_i) |=> (wb_ack_o ^ wb_err_o))
      else $error("request not answered in one cycle");
   err_unmapped_a: assert property ((wb_ack_o || wb_err_o) |->
      (wb_err_o == ($past(wb_adr_i[7:2]) > 6'h16)))
      else $error("error answer does not match address");
   ack_err_excl_a: assert property (!(wb_ack_o && wb_err_o))
      else $error("ack and err together");
   dat_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000)
      else $error("read data outside ack");
   block_err_gate_a: assert property (pcs_block_err |-> (fec_on && fec_err_ind) ||
      ($past(fec_on) && $past(fec_err_ind)))
      else $error("block error while indication off");
   fec_cfg_hold_a: assert property ($changed(fec_on) |->
      $past(wb_ack_o && wb_we_i) || $past(wb_ack_o && wb_we_i, 2))
      else $error("fec enable changed without write");
   test_mode_hold_a: assert property ($changed(test_mode_on) |->
      $past(wb_ack_o && wb_we_i) || $past(wb_ack_o && wb_we_i, 2))
      else $error("test mode changed without write");
endmodule
bind pcs_test_lane_fec_ctrl pcs_ctrl_checker u_chk
(
   .clk(clk), .rstn(rstn), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
   .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o),
   .test_mode_on(test_mode_on), .fec_on(fec_on), .fec_err_ind(fec_err_ind),
   .pcs_block_err(pcs_block_err)
);

/* File: testbench/serdes_far_end.sv */
`timescale 1ns/1ps
// far-side lanes: loop our transmit back, or send a fixed word
module serdes_far_end
(
   input  wire         clk,
   input  wire         rstn,
   input  wire  [63:0] tx_word,
   input  wire  [63:0] drive_word,
   input  wire         loop_on,
   input  wire         corrupt,
   output logic [63:0] rx_word
);
   always @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         rx_word <= 64'h0000_0000_0000_0000;
      else
         rx_word <= loop_on ? (tx_word ^ {63'h0, corrupt}) : drive_word;
   end
endmodule

/* File: testbench/pcs_test_lane_fec_ctrl_tb.sv */
`timescale 1ns/1ps
`include "pcs_ctrl_map.vh"
module pcs_test_lane_fec_ctrl_tb;
   logic        clk = 0, rstn = 0, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
   logic [7:0]  wb_adr_i = 0;
   logic [31:0] wb_dat_i = 0, wb_dat_o, xaui_idle_cfg, rd;
   logic [63:0] pcs_tx_data = 64'h0123_4567_89ab_cdef, serdes_tx_data, serdes_rx_data;
   logic [63:0] pcs_rx_data, ex, drv = 64'hf00d_1234_5a5a_c3c1;
   logic        wb_ack_o, wb_err_o, test_mode_on, fec_on, fec_err_ind, fec_tx_flip;
   logic        fec_rx_flip, pcs_block_err, er, loop_on = 0, corrupt = 0, seen_blk = 0;
   logic        fec_lock = 0, fec_corr_evt = 0, fec_uncorr_evt = 0, wake_err_evt = 0;
   logic [5:0]  c, cfg_row [8] = '{6'h00, 6'h01, 6'h02, 6'h04, 6'h08, 6'h10, 6'h20, 6'h3f};
   logic [5:0]  r_idx [8] = '{`A_SEED_A_HIGH, `A_SEED_B_HIGH, `A_SEED_B_LOW, `A_TX_PAT_HIGH,
                             `A_RX_PAT_LOW, `A_XIDLE_STATUS, `A_RIDLE_STATUS, `A_XIDLE_CFG};
   logic [31:0] r_w [8] = '{32'hffff_ffff, 32'hffff_ffff, 32'h1234_5678, 32'ha5a5_0f0f,
                           32'h5a5a_c3c3, 32'hffff_ffff, 32'hffff_ffff, 32'h1357_9bdf};
   logic [31:0] r_e [8] = '{32'h03ff_ffff, 32'h03ff_ffff, 32'h1234_5678, 32'ha5a5_0f0f,
                           32'h5a5a_c3c3, 32'h0000_00a5, 32'h0000_005c, 32'h1357_9bdf};
   int          err_total = 0, checks = 0, i;
   always #20 clk = ~clk;
   always @(posedge clk)
      if (pcs_block_err === 1'b1)
         seen_blk <= 1;
   pcs_test_lane_fec_ctrl u_dut
   (
      .clk(clk), .rstn(rstn), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
      .wb_adr_i(wb_adr_i), .wb_sel_i(4'hf), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
      .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o), .pcs_tx_data(pcs_tx_data),
      .serdes_tx_data(serdes_tx_data), .serdes_rx_data(serdes_rx_data),
      .pcs_rx_data(pcs_rx_data), .test_mode_on(test_mode_on), .fec_on(fec_on),
      .fec_err_ind(fec_err_ind), .fec_tx_flip(fec_tx_flip), .fec_rx_flip(fec_rx_flip),
      .fec_lock(fec_lock), .fec_corr_evt(fec_corr_evt), .fec_uncorr_evt(fec_uncorr_evt),
      .pcs_block_err(pcs_block_err), .wake_err_evt(wake_err_evt),
      .xaui_idle_status(32'h0000_00a5), .baser_idle_status(32'h0000_005c),
      .xaui_idle_cfg(xaui_idle_cfg)
   );
   serdes_far_end u_far
   (
      .clk(clk), .rstn(rstn), .tx_word(serdes_tx_data), .drive_word(drv),
      .loop_on(loop_on), .corrupt(corrupt), .rx_word(serdes_rx_data)
   );
   function automatic logic [63:0] rev64(input logic [63:0] d);
      for (int k = 0; k < 64; k++)
         rev64[k] = d[63 - k];
   endfunction
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      checks++;
      if (got !== exp)
      begin
         err_total++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wb(input logic we, input logic [5:0] idx, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      wb_cyc_i <= 1;
      wb_stb_i <= 1;
      wb_we_i <= we;
      wb_adr_i <= {idx, 2'b00};
      wb_dat_i <= d;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1 && n < 50);
      if (n >= 50)
         err_total++;
      rd = wb_dat_o;
      er = wb_err_o;
      wb_cyc_i <= 0;
      wb_stb_i <= 0;
   endtask
   task automatic pulse(input int w);
      @(posedge clk);
      fec_corr_evt <= (w == 0);
      fec_uncorr_evt <= (w == 1);
      wake_err_evt <= (w == 2);
      repeat (5) @(posedge clk);
      {fec_corr_evt, fec_uncorr_evt, wake_err_evt} <= 3'b000;
      repeat (5) @(posedge clk);
   endtask
   task final_report;
      if (err_total == 0 && checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   initial
   begin
      #(40 * 30000);
      err_total++;
      final_report;
   end
   initial
   begin
      repeat (20) @(posedge clk);
      rstn <= 1;
      for (i = 0; i < 8; i++)
      begin
         wb(1, r_idx[i], r_w[i]);
         wb(0, r_idx[i], 0);
         chk(rd, r_e[i]);
      end
      chk(xaui_idle_cfg, 32'h1357_9bdf);
      for (i = 0; i < 8; i++)
      begin
         c = cfg_row[i];
         wb(1, `A_LANE_CFG, {26'h0, c});
         repeat (8) @(posedge clk);
         ex = c[2] ? ~pcs_tx_data : pcs_tx_data;
         ex = c[3] ? {ex[15:0], ex[31:16], ex[47:32], ex[63:48]} : ex;
         ex = c[4] ? rev64(ex) : ex;
         chk(serdes_tx_data, ex);
         ex = c[5] ? rev64(drv) : drv;
         ex = c[0] ? ~ex : ex;
         ex = c[1] ? {ex[15:0], ex[31:16], ex[47:32], ex[63:48]} : ex;
         chk(pcs_rx_data, ex);
      end
      wb(1, `A_LANE_CFG, 0);
      loop_on <= 1;
      wb(1, `A_TX_PAT_LOW, 32'h5a5a_c3c3);
      wb(1, `A_RX_PAT_HIGH, 32'ha5a5_0f0f);
      wb(1, `A_TEST_CFG, 32'h0000_0001);
      repeat (3) @(posedge clk);
      chk(test_mode_on, 0);
      for (i = 0; i < 4; i++)
      begin
         wb(1, `A_TEST_CFG, 32'h0000_0403 | (i * 32'h0000_0014));
         repeat (40) @(posedge clk);
         chk(test_mode_on, 1);
         wb(1, `A_ERR_COUNT, 0);
         repeat (20) @(posedge clk);
         wb(0, `A_CHK_STATUS, 0);
         chk(rd[0], 1);
         wb(0, `A_ERR_COUNT, 0);
         chk(rd, 0);
      end
      corrupt <= 1;
      repeat (5) @(posedge clk);
      corrupt <= 0;
      repeat (10) @(posedge clk);
      wb(0, `A_ERR_COUNT, 0);
      chk(rd != 0, 1);
      wb(1, `A_ERR_COUNT, 0);
      wb(0, `A_ERR_COUNT, 0);
      chk(rd, 0);
      wb(1, `A_TEST_CFG, 0);
      fec_lock <= 1;
      wb(1, `A_CORR_LIMIT, 2);
      wb(1, `A_UNCORR_LIMIT, 0);
      wb(1, `A_FEC_CFG, 32'h0000_000f);
      repeat (6) @(posedge clk);
      chk({fec_on, fec_err_ind, fec_tx_flip, fec_rx_flip}, 4'hf);
      wb(0, `A_FEC_STATUS, 0);
      chk(rd, 1);
      repeat (3) pulse(0);
      pulse(1);
      fec_lock <= 0;
      repeat (8) @(posedge clk);
      wb(0, `A_FEC_CORR, 0);
      chk(rd, 3);
      wb(0, `A_FEC_UNCORR, 0);
      chk(rd, 1);
      wb(0, `A_FEC_STICKY, 0);
      chk(rd, 7);
      chk(seen_blk, 1);
      wb(1, `A_FEC_CFG, 32'h0000_001f);
      wb(1, `A_FEC_CFG, 32'h0000_000f);
      repeat (3) @(posedge clk);
      wb(0, `A_FEC_CORR, 0);
      chk(rd, 0);
      wb(1, `A_FEC_STICKY, 7);
      wb(0, `A_FEC_STICKY, 0);
      chk(rd, 0);
      pulse(2);
      wb(0, `A_WAKE_COUNT, 0);
      chk(rd, 1);
      wb(0, 6'h17, 0);
      chk({er, rd}, {1'b1, 32'h0000_0000});
      rstn <= 0;
      repeat (3) @(posedge clk);
      rstn <= 1;
      wb(0, `A_CORR_LIMIT, 0);
      chk({fec_on, rd}, {1'b0, 32'hffff_ffff});
      final_report;
   end
endmodule
